/* verilog/ccc_pkg.sv */
// Package of offsets, field positions, reset values and codes for the core control and context status bank
package ccc_pkg;

    // ==========================================
    // Register word offsets (byte addresses on the bus)
    localparam logic [3:0]  CORE_CONTROL_ADDR   = 4'h0;   // Core control register
    localparam logic [3:0]  CONTEXT_STATUS_ADDR = 4'h4;   // Context status, read only
    localparam logic [3:0]  STATUS_REG_ADDR     = 4'h8;   // Status register (priority bits)
    localparam logic [3:0]  CONTEXT_CMD_ADDR    = 4'hC;   // Manual register set select

    // ==========================================
    // Core control field positions
    localparam int INT_MUL_BIT    = 0;    // Integer / fractional multiply
    localparam int ROUND_BIT      = 1;    // Rounding mode
    localparam int FRAME_BIT      = 2;    // Stack frame active
    localparam int PRIO_MSB_BIT   = 3;    // Priority level msb
    localparam logic [15:0] CORE_CONTROL_WMASK = 16'h000F;   // Writable bits
    localparam logic [15:0] CORE_CONTROL_RESET = 16'h0000;   // Value after reset

    // ==========================================
    // Status register priority field
    localparam int PRIO_LSB_POS   = 5;    // Bits 7:5 hold the low priority bits
    localparam logic [15:0] STATUS_REG_WMASK = 16'h00E0;     // Writable bits
    localparam logic [15:0] STATUS_REG_RESET = 16'h0000;     // Value after reset

    // ==========================================
    // Context status field positions
    localparam int CUR_CTX_POS    = 8;    // Current set id, bits 10:8
    localparam int MAN_CTX_POS    = 0;    // Manual set id, bits 2:0
    localparam logic [2:0]  CTX_DEFAULT  = 3'h0;   // Default register set
    localparam logic [2:0]  CTX_MAX_ALT  = 3'h4;   // Alternate set 4
    localparam logic [2:0]  CTX_RESERVED = 3'h7;   // Reserved code

    // ==========================================
    // Data space bounds
    localparam logic [15:0] FULL_SPACE_LOW  = 16'h0000;  // Bottom of full range
    localparam logic [15:0] FULL_SPACE_HIGH = 16'hFFFF;  // Top of full range
    localparam logic [15:0] BASE_SPACE_MASK = 16'h7FFF;  // Base data space window

    // Bus answer for an unmapped read
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Rounding kinds for the datapath
    typedef enum logic {
        CCC_ROUND_CONVERGENT,
        CCC_ROUND_BIASED
    } ccc_round_e;

endpackage

/* verilog/ccc_space_map.sv */
// Address resolver for frame and stack pointer accesses
`timescale 1ns/1ps
module ccc_space_map (
    // Control
    input  wire logic        frameActive,    // Stack frame active
    // Request
    input  wire logic        isFramePtr,     // Access through frame or stack pointer
    input  wire logic [15:0] effAddr,        // Effective address
    input  wire logic [7:0]  readPage,       // Data space read page
    // Result
    output logic      [23:0] physAddr        // Resolved address
);

    // ==========================================
    // Resolution
    // Pointer with frame active: full 16-bit range, page ignored; frame inactive: base space only; other accesses paged
    always_comb begin
        if (isFramePtr && frameActive) begin
            physAddr = {8'h00, effAddr};
        end else if (isFramePtr) begin
            physAddr = {8'h00, effAddr & ccc_pkg::BASE_SPACE_MASK};
        end else begin
            physAddr = {readPage, effAddr};
        end
    end

endmodule

/* verilog/ccc_ctx_track.sv */
// Tracker of the current and manually selected working register set
`timescale 1ns/1ps
module ccc_ctx_track (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // Events from the core
    input  wire logic       switchValid,     // Any register set change
    input  wire logic       switchManual,    // Change chosen by software
    input  wire logic [2:0] switchId,        // New set id
    // State
    output logic      [2:0] curId,           // Set now in use
    output logic      [2:0] manId            // Last manual choice
);

    // All state in one struct
    typedef struct packed {
        logic [2:0] cur;   // Current id
        logic [2:0] man;   // Manual id
    } ccc_ctx_s;

    ccc_ctx_s st;        // Registered state
    ccc_ctx_s next_st;   // Next state

    // Reserved codes are never stored
    logic idOk;
    assign idOk = (switchId <= ccc_pkg::CTX_MAX_ALT);

    // ==========================================
    // Next state
    always_comb begin
        next_st = st;
        if (switchValid && idOk) begin
            next_st.cur = switchId;
            if (switchManual) begin
                next_st.man = switchId;
            end
        end
    end

    // ==========================================
    // Registers, cleared at reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign curId = st.cur;
    assign manId = st.man;

    // Manual id only moves on a manual switch
    property p_man_hold;
        @(posedge mclk) disable iff (!reset_n)
        !(switchValid && switchManual) |=> (manId == $past(manId));
    endproperty
    a_man_hold: assert property (p_man_hold) else $error("manual id moved without manual select");

    // Current id follows a legal switch
    property p_cur_follow;
        @(posedge mclk) disable iff (!reset_n)
        (switchValid && switchId <= 3'h4) |=> (curId == $past(switchId));
    endproperty
    a_cur_follow: assert property (p_cur_follow) else $error("current id did not follow switch");

    // Stored ids never carry the reserved code
    property p_no_reserved;
        @(posedge mclk) disable iff (!reset_n)
        (curId <= 3'h4) && (manId <= 3'h4);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("context id out of range");

endmodule

/* verilog/ccc_core_control.sv */
// Core control and context status register bank with Avalon-MM slave
// ==========================================
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ccc_core_control (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [1:0]  response,
    // Register set switch events from the core
    input  wire logic        ctxSwitchValid,
    input  wire logic [2:0]  ctxSwitchId,
    // Frame / stack pointer access
    input  wire logic        ptrAccess,
    input  wire logic [15:0] ptrAddr,
    input  wire logic [7:0]  data_space_read_page,
    output logic      [23:0] ptrPhysAddr,
    // Datapath controls
    output logic             stack_frame_active,
    output logic             rounding_select,
    output logic             integer_multiply_select,
    output logic             roundBiased,
    output logic             mulFractional,
    output logic      [3:0]  cpuPriority
);

    // ==========================================
    // State
    typedef struct packed {
        logic [15:0] coreCtl;     // Core control
        logic [15:0] statusReg;   // Status register
        logic        ackPend;     // Answer cycle
        logic [31:0] rdata;       // Read data
        logic [1:0]  resp;        // Response code
        logic        manReq;      // Manual select strobe
        logic [2:0]  manReqId;    // Requested set
    } ccc_bank_s;

    ccc_bank_s st;        // Registered state
    ccc_bank_s next_st;   // Next state

    logic [2:0]  curId;       // Current set id
    logic [2:0]  manId;       // Manual set id
    logic [15:0] ctxStatus;   // Assembled context status
    logic [15:0] wmask;       // Byte-lane write mask
    logic        swValid;     // Any switch event
    logic [2:0]  swId;        // Switch id merged

    // ==========================================
    // Context status word, unused bits tied low
    always_comb begin
        ctxStatus = 16'h0000;
        ctxStatus[ccc_pkg::CUR_CTX_POS +: 3] = curId;
        ctxStatus[ccc_pkg::MAN_CTX_POS +: 3] = manId;
    end

    // Byte enables to bit mask
    assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    // Software selection takes the switch port; hardware switch otherwise
    assign swValid = st.manReq | ctxSwitchValid;
    assign swId    = st.manReq ? st.manReqId : ctxSwitchId;

    // ==========================================
    // Bus and register next state
    always_comb begin
        next_st         = st;
        next_st.ackPend = 1'b0;
        next_st.manReq  = 1'b0;
        if ((read || write) && !st.ackPend) begin
            // Take cycle: latch read data and response, answer the next cycle
            next_st.ackPend = 1'b1;
            next_st.resp    = 2'b00;
            next_st.rdata   = ccc_pkg::UNMAPPED_DATA;
            if (address == ccc_pkg::CORE_CONTROL_ADDR) begin
                // Mode bits and priority msb
                if (read) begin
                    next_st.rdata = {16'h0000, st.coreCtl};
                end
            end else if (address == ccc_pkg::CONTEXT_STATUS_ADDR) begin
                // Read only: a write is answered but stores nothing
                if (read) begin
                    next_st.rdata = {16'h0000, ctxStatus};
                end
            end else if (address == ccc_pkg::STATUS_REG_ADDR) begin
                // Low priority bits
                if (read) begin
                    next_st.rdata = {16'h0000, st.statusReg};
                end
            end else if (address == ccc_pkg::CONTEXT_CMD_ADDR) begin
                // Last manual choice
                if (read) begin
                    next_st.rdata = {29'h0, manId};
                end
            end else begin
                // Unmapped: decode error
                next_st.resp = 2'b11;
            end
        end else if (write && st.ackPend) begin
            // Answer cycle: the write lands on the edge where the master sees waitrequest low
            if (address == ccc_pkg::CORE_CONTROL_ADDR) begin
                next_st.coreCtl = (st.coreCtl & ~(wmask & ccc_pkg::CORE_CONTROL_WMASK))
                                | (writedata[15:0] & wmask & ccc_pkg::CORE_CONTROL_WMASK);
            end else if (address == ccc_pkg::STATUS_REG_ADDR) begin
                next_st.statusReg = (st.statusReg & ~(wmask & ccc_pkg::STATUS_REG_WMASK))
                                  | (writedata[15:0] & wmask & ccc_pkg::STATUS_REG_WMASK);
            end else if (address == ccc_pkg::CONTEXT_CMD_ADDR && byteenable[0]) begin
                // Software choice of register set
                next_st.manReq   = 1'b1;
                next_st.manReqId = writedata[2:0];
            end
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st           <= '0;
            st.coreCtl   <= ccc_pkg::CORE_CONTROL_RESET;
            st.statusReg <= ccc_pkg::STATUS_REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Bus outputs
    assign waitrequest = (read || write) && !st.ackPend;
    assign readdata    = st.rdata;
    assign response    = st.resp;

    // ==========================================
    // Control outputs
    assign stack_frame_active      = st.coreCtl[ccc_pkg::FRAME_BIT];
    assign rounding_select         = st.coreCtl[ccc_pkg::ROUND_BIT];
    assign integer_multiply_select = st.coreCtl[ccc_pkg::INT_MUL_BIT];
    assign roundBiased             = rounding_select;
    assign mulFractional           = !integer_multiply_select;
    // Priority msb above status bits 7:5
    assign cpuPriority = {st.coreCtl[ccc_pkg::PRIO_MSB_BIT],
                          st.statusReg[ccc_pkg::PRIO_LSB_POS +: 3]};

    // ==========================================
    // Sub blocks
    ccc_space_map u_space (
        .frameActive (stack_frame_active),
        .isFramePtr  (ptrAccess),
        .effAddr     (ptrAddr),
        .readPage    (data_space_read_page),
        .physAddr    (ptrPhysAddr)
    );

    ccc_ctx_track u_ctx (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .switchValid  (swValid),
        .switchManual (st.manReq),
        .switchId     (swId),
        .curId        (curId),
        .manId        (manId)
    );

    // ==========================================
    // Checks
    property p_frame_full;
        @(posedge mclk) disable iff (!reset_n)
        (ptrAccess && stack_frame_active) |-> (ptrPhysAddr == {8'h00, ptrAddr});
    endproperty
    a_frame_full: assert property (p_frame_full) else $error("frame pointer not full range");

    property p_frame_base;
        @(posedge mclk) disable iff (!reset_n)
        (ptrAccess && !stack_frame_active) |-> (ptrPhysAddr[23:15] == 9'h000);
    endproperty
    a_frame_base: assert property (p_frame_base) else $error("frame pointer left base space");

    property p_round;
        @(posedge mclk) disable iff (!reset_n)
        (write && !waitrequest && address == 4'h0 && byteenable[0])
            |=> (roundBiased == $past(writedata[1]));
    endproperty
    a_round: assert property (p_round) else $error("rounding mode not taken from write");

    property p_imul;
        @(posedge mclk) disable iff (!reset_n)
        (write && !waitrequest && address == 4'h0 && byteenable[0])
            |=> (mulFractional == !$past(writedata[0]));
    endproperty
    a_imul: assert property (p_imul) else $error("multiply mode not taken from write");

    property p_prio;
        @(posedge mclk) disable iff (!reset_n)
        (write && !waitrequest && address == 4'h8 && byteenable[0])
            |=> (cpuPriority[2:0] == $past(writedata[7:5]));
    endproperty
    a_prio: assert property (p_prio) else $error("priority low bits not from status");

    property p_ctx_zero;
        @(posedge mclk) disable iff (!reset_n)
        (read && !waitrequest && address == 4'h4) |-> (readdata[31:11] == 21'h0 && readdata[7:3] == 5'h0);
    endproperty
    a_ctx_zero: assert property (p_ctx_zero) else $error("unused context bits not zero");

    property p_man_sel;
        @(posedge mclk) disable iff (!reset_n)
        (write && !waitrequest && address == 4'hC && byteenable[0] && writedata[2:0] <= 3'h4)
            |=> ##1 (ctxStatus[2:0] == $past(writedata[2:0], 2) && ctxStatus[10:8] == $past(writedata[2:0], 2));
    endproperty
    a_man_sel: assert property (p_man_sel) else $error("manual select not reported");

    // Every request sees exactly one wait cycle
    property p_one_wait;
        @(posedge mclk) disable iff (!reset_n)
        ((read || write) && waitrequest) |=> !waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");

    // Core control read back shows the live mode bits, upper bits zero
    property p_core_read;
        @(posedge mclk) disable iff (!reset_n)
        (read && !waitrequest && address == ccc_pkg::CORE_CONTROL_ADDR)
            |-> (readdata[31:4] == 28'h0
                 && readdata[2:0] == {stack_frame_active, rounding_select, integer_multiply_select});
    endproperty
    a_core_read: assert property (p_core_read) else $error("core control read back wrong");

    // Status read back carries the low priority bits only
    property p_status_read;
        @(posedge mclk) disable iff (!reset_n)
        (read && !waitrequest && address == ccc_pkg::STATUS_REG_ADDR)
            |-> (readdata[31:8] == 24'h0 && readdata[4:0] == 5'h00 && readdata[7:5] == cpuPriority[2:0]);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read back wrong");

    // Context read back matches the tracker when no switch raced the take
    property p_ctx_read;
        @(posedge mclk) disable iff (!reset_n)
        (read && !waitrequest && address == ccc_pkg::CONTEXT_STATUS_ADDR && !$past(swValid))
            |-> (readdata[10:8] == curId && readdata[2:0] == manId);
    endproperty
    a_ctx_read: assert property (p_ctx_read) else $error("context ids not reported");

    // A write to context status never moves it
    property p_ctx_ro;
        @(posedge mclk) disable iff (!reset_n)
        (write && !waitrequest && address == ccc_pkg::CONTEXT_STATUS_ADDR && !swValid)
            |=> $stable(ctxStatus);
    endproperty
    a_ctx_ro: assert property (p_ctx_ro) else $error("context status moved on write");

    // A pending manual choice wins over a hardware switch in the same cycle
    property p_man_first;
        @(posedge mclk) disable iff (!reset_n)
        (st.manReq && ctxSwitchValid && st.manReqId <= ccc_pkg::CTX_MAX_ALT)
            |=> (curId == $past(st.manReqId));
    endproperty
    a_man_first: assert property (p_man_first) else $error("hardware switch beat manual choice");

    // Unmapped addresses answer with a decode error
    property p_decode_err;
        @(posedge mclk) disable iff (!reset_n)
        ((read || write) && !waitrequest
         && address != ccc_pkg::CORE_CONTROL_ADDR && address != ccc_pkg::CONTEXT_STATUS_ADDR
         && address != ccc_pkg::STATUS_REG_ADDR && address != ccc_pkg::CONTEXT_CMD_ADDR)
            |-> (response == 2'b11);
    endproperty
    a_decode_err: assert property (p_decode_err) else $error("unmapped access not refused");

endmodule

/* sim/ccc_core_control_bench.sv */
// Self-checking bench for the core control and context status register bank
`timescale 1ns/1ps
module ccc_core_control_bench;

    // ==========================================
    // Clock, reset and stimulus signals
    logic        mclk;                  // 20 MHz clock
    logic        reset_n;               // Active low reset
    logic [3:0]  address;               // Bus byte address
    logic        read;                  // Read strobe
    logic        write;                 // Write strobe
    logic [31:0] writedata;             // Write data
    logic [3:0]  byteenable;            // Byte lanes
    logic [31:0] readdata;              // Read data
    logic        waitrequest;           // Slave stall
    logic [1:0]  response;              // Bus response code
    logic        ctxSwitchValid;        // Hardware set switch pulse
    logic [2:0]  ctxSwitchId;           // Hardware set id
    logic        ptrAccess;             // Pointer access request
    logic [15:0] ptrAddr;               // Pointer effective address
    logic [7:0]  readPage;              // Data space read page
    logic [23:0] ptrPhysAddr;           // Resolved address
    logic        frameAct;              // Stack frame active output
    logic        roundSel;              // Rounding select output
    logic        intMulSel;             // Integer multiply output
    logic        roundBiased;           // Biased rounding to datapath
    logic        mulFractional;         // Fractional multiply to datapath
    logic [3:0]  cpuPriority;           // Priority level
    int          errors;                // Mismatch count
    int          cmp_count;             // Comparison count
    int          cycles;                // Timeout counter
    logic [31:0] rd;                    // Last read data
    logic [1:0]  rsp;                   // Last response

    // ==========================================
    // Device under test
    ccc_core_control i_dut (
        .mclk                    (mclk),
        .reset_n                 (reset_n),
        .address                 (address),
        .read                    (read),
        .write                   (write),
        .writedata               (writedata),
        .byteenable              (byteenable),
        .readdata                (readdata),
        .waitrequest             (waitrequest),
        .response                (response),
        .ctxSwitchValid          (ctxSwitchValid),
        .ctxSwitchId             (ctxSwitchId),
        .ptrAccess               (ptrAccess),
        .ptrAddr                 (ptrAddr),
        .data_space_read_page    (readPage),
        .ptrPhysAddr             (ptrPhysAddr),
        .stack_frame_active      (frameAct),
        .rounding_select         (roundSel),
        .integer_multiply_select (intMulSel),
        .roundBiased             (roundBiased),
        .mulFractional           (mulFractional),
        .cpuPriority             (cpuPriority)
    );

    // Clock generator, 50 ns period
    always #25 mclk = ~mclk;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            close_out();
        end
    end

    // Compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer; held until waitrequest is low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        address   <= a;
        write     <= wr;
        read      <= !wr;
        writedata <= {16'h0000, d};
        // Held until waitrequest is seen low at a rising edge; only the hang guard ends a wait
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        rd  = readdata;
        rsp = response;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    // Read a register and compare data and response
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 16'h0000);
        chk(what, exp, rd);
        chk("response", 32'h0000_0000, {30'h0, rsp});
    endtask

    // Reset values of core control, context status and status register
    task automatic t_reset;
        rd_chk("core_control", ccc_pkg::CORE_CONTROL_ADDR, 32'h0000_0000);
        rd_chk("context_status", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0000);
        rd_chk("status_register", ccc_pkg::STATUS_REG_ADDR, 32'h0000_0000);
        chk("priority", 32'h0, {28'h0, cpuPriority});
    endtask

    // Mode bits, one at a time, and their datapath meaning
    task automatic t_modes;
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ccc_pkg::CORE_CONTROL_ADDR, 16'h0001 << i);
            @(negedge mclk);
            chk("mode", 32'h0000_0001 << i, {29'h0, frameAct, roundSel, intMulSel});
            chk("datapath", {30'h0, i == 1, i != 0}, {30'h0, roundBiased, mulFractional});
        end
        // High lane only: the mode bits in the low byte stay put
        @(posedge mclk);
        byteenable <= 4'h2;
        bus(1'b1, ccc_pkg::CORE_CONTROL_ADDR, 16'h000B);
        byteenable <= 4'hF;
        rd_chk("core lanes", ccc_pkg::CORE_CONTROL_ADDR, 32'h0000_0004);
    endtask

    // Priority is msb from core_control above status bits 7:5
    task automatic t_priority;
        bus(1'b1, ccc_pkg::CORE_CONTROL_ADDR, 16'hFFFF);
        bus(1'b1, ccc_pkg::STATUS_REG_ADDR, 16'hFFBF);
        rd_chk("core_control", ccc_pkg::CORE_CONTROL_ADDR, 32'h0000_000F);
        rd_chk("status_register", ccc_pkg::STATUS_REG_ADDR, 32'h0000_00A0);
        chk("priority", 32'h0000_000D, {28'h0, cpuPriority});
        bus(1'b1, ccc_pkg::CORE_CONTROL_ADDR, 16'h0000);
        @(negedge mclk);
        chk("priority", 32'h0000_0005, {28'h0, cpuPriority});
    endtask

    // Pointer addressing with the frame active and inactive
    task automatic t_space;
        @(posedge mclk);
        ptrAccess <= 1'b1;
        ptrAddr   <= 16'hF234;
        readPage  <= 8'h5A;
        @(negedge mclk);
        chk("phys inactive", 32'h0000_7234, {8'h00, ptrPhysAddr});
        bus(1'b1, ccc_pkg::CORE_CONTROL_ADDR, 16'h0004);
        @(negedge mclk);
        chk("phys active", 32'h0000_F234, {8'h00, ptrPhysAddr});
        @(posedge mclk);
        ptrAddr <= 16'hFFFF;
        @(negedge mclk);
        chk("phys top", 32'h0000_FFFF, {8'h00, ptrPhysAddr});
        @(posedge mclk);
        ptrAccess <= 1'b0;
        @(negedge mclk);
        chk("phys paged", 32'h005A_FFFF, {8'h00, ptrPhysAddr});
    endtask

    // Manual select, hardware switches, reserved ids and refused writes
    task automatic t_context;
        bus(1'b1, ccc_pkg::CONTEXT_CMD_ADDR, 16'h0003);
        repeat (2) @(posedge mclk);
        rd_chk("ctx manual", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0303);
        @(posedge mclk);
        ctxSwitchValid <= 1'b1;
        ctxSwitchId    <= 3'h4;
        @(posedge mclk);
        ctxSwitchId    <= 3'h7;
        @(posedge mclk);
        ctxSwitchValid <= 1'b0;
        rd_chk("ctx hw", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0403);
        bus(1'b1, ccc_pkg::CONTEXT_STATUS_ADDR, 16'hFFFF);
        rd_chk("ctx ro", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0403);
        bus(1'b1, ccc_pkg::CONTEXT_CMD_ADDR, 16'h0007);
        repeat (2) @(posedge mclk);
        rd_chk("ctx reserved", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0403);
        // Hardware switch still high when the manual choice is applied
        @(posedge mclk);
        ctxSwitchValid <= 1'b1;
        ctxSwitchId    <= 3'h1;
        bus(1'b1, ccc_pkg::CONTEXT_CMD_ADDR, 16'h0002);
        @(posedge mclk);
        ctxSwitchValid <= 1'b0;
        @(posedge mclk);
        rd_chk("ctx race", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0202);
        bus(1'b1, ccc_pkg::CONTEXT_CMD_ADDR, 16'h0000);
        repeat (2) @(posedge mclk);
        rd_chk("ctx default", ccc_pkg::CONTEXT_STATUS_ADDR, 32'h0000_0000);
        bus(1'b0, 4'h2, 16'h0000);
        chk("unmapped rsp", 32'h0000_0003, {30'h0, rsp});
    endtask

    // Reset in mid-run clears every register again
    task automatic t_rst_mid;
        bus(1'b1, ccc_pkg::CORE_CONTROL_ADDR, 16'h000F);
        bus(1'b1, ccc_pkg::STATUS_REG_ADDR, 16'h00E0);
        bus(1'b1, ccc_pkg::CONTEXT_CMD_ADDR, 16'h0002);
        repeat (2) @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
    endtask

    // Verdict and end of run
    task automatic close_out;
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        mclk = 1'b0; reset_n = 1'b0; address = 4'h0; read = 1'b0; write = 1'b0;
        writedata = 32'h0; byteenable = 4'hF; ctxSwitchValid = 1'b0; ctxSwitchId = 3'h0;
        ptrAccess = 1'b0; ptrAddr = 16'h0000; readPage = 8'h00;
        errors = 0; cmp_count = 0; cycles = 0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_modes();
        t_priority();
        t_space();
        t_context();
        t_rst_mid();
        close_out();
    end

endmodule
